// file: core/flash_prog_pkg.sv
// Shared constants, state types and carriers for the program-command front end.
// Assumes one 125 MHz core clock and SPI pins sampled as asynchronous inputs.
package flash_prog_pkg;
	localparam logic [7:0]  CMD_DUAL_PAGE = 8'hA2;
	localparam logic [7:0]  CMD_QUAD_PAGE = 8'h32;
	localparam logic [7:0]  CMD_SEQ_A     = 8'hAD;
	localparam logic [7:0]  CMD_SEQ_B     = 8'hAF;
	localparam logic [5:0]  CMD_BITS      = 6'h08;
	localparam logic [5:0]  HEADER_BITS   = 6'h20;        // command plus 24 address bits
	localparam logic [23:0] ARRAY_LAST_ADDR = 24'h0FFFFF;
	localparam logic [8:0]  PAGE_BYTES    = 9'h100;
	localparam int          FIFO_DEPTH    = 16;
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned BYTE_PROGRAM_TIME_NS = 30000;    // byte_program_time
	localparam int unsigned PAGE_PROGRAM_TIME_NS = 1500000;  // page_program_time
	localparam int unsigned BYTE_PROGRAM_CYCLES =
		(BYTE_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PAGE_PROGRAM_CYCLES =
		(PAGE_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_DATA, PH_IGNORE} phase_t;
	typedef enum logic [1:0] {OP_NONE, OP_DUAL, OP_QUAD, OP_SEQ} op_t;
	typedef enum logic [1:0] {ENG_IDLE, ENG_DRAIN, ENG_WAIT} engine_t;

	typedef struct packed {
		logic hold;
		logic wp;
		logic so;
		logic si;
		logic sck;
		logic cs_n;
	} pins_t;

	typedef struct packed {
		logic [23:0] addr;
		logic [7:0]  data;
	} prog_word_t;

	typedef struct packed {
		pins_t                s1;
		pins_t                s2;
		pins_t                s3;
		pins_t                filt;
		phase_t               phase;
		op_t                  op;
		logic                 seq_first;
		logic [5:0]           bit_cnt;
		logic [7:0]           cmd;
		logic [23:0]          start;
		logic [7:0]           shreg;
		logic [2:0]           byte_phase;
		logic                 got_byte;
		logic [7:0]           wptr;
		logic [255:0][7:0]    page;
		logic [255:0]         valid;
		logic [7:0]           last_byte;
		logic                 seq_mode;
		logic [23:0]          seq_addr;
		logic                 job_seq;
		logic                 at_end;
		engine_t              eng;
		logic [8:0]           idx;
		logic [19:0]          timer;
		logic                 busy;
		logic                 wel_clear;
		logic                 pe;
		logic                 ee;
	} core_state_t;
endpackage

// file: core/flash_prog_frontend.sv
// Program-command front end: pin sampling, frame decode, page buffer, program FIFO, timing.
// Assumes the enable latch, protection map and array writer live outside on core_clk.
`timescale 1ns/1ps
`default_nettype none

module prog_word_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             resetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 count;
	} fifo_state_t;
	fifo_state_t st;
	fifo_state_t next_st;
	logic        push;
	logic        pop;

	// depth must be a power of two so the pointers wrap by themselves
	assign in_ready  = st.count != (AW+1)'(DEPTH);
	assign out_valid = st.count != '0;
	assign out_data  = st.mem[st.rd];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wr] = in_data;
			next_st.wr = st.wr + 1'b1;
		end
		if (pop)
			next_st.rd = st.rd + 1'b1;
		if (push && !pop)
			next_st.count = st.count + 1'b1;
		else if (pop && !push)
			next_st.count = st.count - 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (!resetn)
			st <= '0;
		else
			st <= next_st;
	end
endmodule

module flash_prog_frontend #(
	parameter int unsigned PAGE_CYCLES = flash_prog_pkg::PAGE_PROGRAM_CYCLES
) (
	input  wire logic                 core_clk,
	input  wire logic                 resetn,
	input  wire logic                 chip_select_n_pin,
	input  wire logic                 serial_clk_pin,
	input  wire logic                 serial_in_pin,
	input  wire logic                 serial_out_pin_in,
	output logic                      serial_out_pin_out,
	output logic                      serial_out_pin_oe,
	input  wire logic                 write_protect_pin,
	input  wire logic                 pause_io3_pin,
	input  wire logic                 write_enable_latch,
	input  wire logic                 quad_enable,
	output logic                      wel_clear,
	output logic [23:0]               protect_check_addr,
	input  wire logic                 protect_check_hit,
	output logic [23:0]               seq_next_addr,
	input  wire logic                 seq_next_protected,
	input  wire logic                 erase_suspended,
	input  wire logic [7:0]           suspended_block,
	output logic                      busy_flag,
	output logic                      seq_mode,
	output logic                      program_error_flag,
	output logic                      erase_error_flag,
	input  wire logic                 error_clear,
	input  wire logic                 program_fail,
	output logic                      prog_valid,
	input  wire logic                 prog_ready,
	output flash_prog_pkg::prog_word_t prog_word
);
	flash_prog_pkg::core_state_t st;
	flash_prog_pkg::core_state_t next_st;
	flash_prog_pkg::pins_t       raw;
	flash_prog_pkg::pins_t       fnew;
	flash_prog_pkg::prog_word_t  push_word;
	logic [5:0]                  s2v;
	logic [5:0]                  s3v;
	logic [5:0]                  filtv;
	logic [5:0]                  fnew_v;
	logic                        sck_rise;
	logic                        cs_fall;
	logic                        cs_rise;
	logic                        frame_ok;
	logic                        frame_prog;
	logic                        first_check;
	logic                        push_valid;
	logic                        push_ready;
	logic                        eng_done;
	logic                        seq_exit;
	logic [7:0]                  byte_new;
	logic [2:0]                  phase_new;

	// bits each data clock delivers for the active command
	function automatic logic [2:0] lanes(flash_prog_pkg::op_t op);
		unique case (op)
			flash_prog_pkg::OP_DUAL: lanes = 3'h2;
			flash_prog_pkg::OP_QUAD: lanes = 3'h4;
			flash_prog_pkg::OP_NONE,
			flash_prog_pkg::OP_SEQ:  lanes = 3'h1;
		endcase
	endfunction

	// data shift, most significant bits first on the highest-numbered lane
	function automatic logic [7:0] shift_in(flash_prog_pkg::op_t op, logic [7:0] sh, flash_prog_pkg::pins_t p);
		unique case (op)
			flash_prog_pkg::OP_DUAL: shift_in = {sh[5:0], p.so, p.si};
			flash_prog_pkg::OP_QUAD: shift_in = {sh[3:0], p.hold, p.wp, p.so, p.si};
			flash_prog_pkg::OP_NONE,
			flash_prog_pkg::OP_SEQ:  shift_in = {sh[6:0], p.si};
		endcase
	endfunction

	// three-stage sampling; a pin level counts once stages two and three agree
	assign raw   = '{hold: pause_io3_pin, wp: write_protect_pin, so: serial_out_pin_in,
	                 si: serial_in_pin, sck: serial_clk_pin, cs_n: chip_select_n_pin};
	assign s2v   = st.s2;
	assign s3v   = st.s3;
	assign filtv = st.filt;
	for (genvar i = 0; i < 6; i++) begin : g_filt
		assign fnew_v[i] = (s2v[i] == s3v[i]) ? s2v[i] : filtv[i];
	end
	assign fnew     = flash_prog_pkg::pins_t'(fnew_v);
	assign sck_rise = fnew.sck & ~st.filt.sck & ~fnew.cs_n;
	assign cs_fall  = st.filt.cs_n & ~fnew.cs_n;
	assign cs_rise  = ~st.filt.cs_n & fnew.cs_n;

	// frame judgement at release: whole header, at least one byte, byte boundary
	assign frame_prog  = st.op != flash_prog_pkg::OP_NONE;
	assign frame_ok    = st.phase == flash_prog_pkg::PH_DATA && st.byte_phase == '0 && st.got_byte;
	assign first_check = st.op != flash_prog_pkg::OP_SEQ || st.seq_first;
	assign byte_new    = shift_in(st.op, st.shreg, fnew);
	assign phase_new   = st.byte_phase + lanes(st.op);

	// engine feed: one word for sequential mode, else every filled page slot
	assign push_word  = st.job_seq ? {st.seq_addr, st.last_byte}
	                               : {st.start[23:8], st.idx[7:0], st.page[st.idx[7:0]]};
	assign push_valid = st.eng == flash_prog_pkg::ENG_DRAIN
	                    && (st.job_seq || (st.idx != flash_prog_pkg::PAGE_BYTES && st.valid[st.idx[7:0]]));
	assign eng_done   = st.eng == flash_prog_pkg::ENG_WAIT && st.timer == '0 && !prog_valid;
	assign seq_exit   = st.at_end || seq_next_protected
	                    || (erase_suspended && st.seq_addr[23:16] == suspended_block);

	prog_word_fifo #(
		.WIDTH($bits(flash_prog_pkg::prog_word_t)),
		.DEPTH(flash_prog_pkg::FIFO_DEPTH)
	) u_fifo (
		.core_clk (core_clk),
		.resetn   (resetn),
		.in_valid (push_valid),
		.in_ready (push_ready),
		.in_data  (push_word),
		.out_valid(prog_valid),
		.out_ready(prog_ready),
		.out_data (prog_word)
	);

	// the front end never drives serial out; it stays an input in every data phase
	assign serial_out_pin_out = 1'b0;
	assign serial_out_pin_oe  = 1'b0;
	assign wel_clear          = st.wel_clear;
	assign protect_check_addr = st.start;
	assign seq_next_addr      = st.seq_addr;
	assign busy_flag          = st.busy;
	assign seq_mode           = st.seq_mode;
	assign program_error_flag = st.pe;
	assign erase_error_flag   = st.ee;

	// frame decode, page buffer, program engine and flags
	always_comb begin
		next_st           = st;
		next_st.s1        = raw;
		next_st.s2        = st.s1;
		next_st.s3        = st.s2;
		next_st.filt      = fnew;
		next_st.wel_clear = 1'b0;
		// frame start wipes the per-frame counters and buffer occupancy
		if (cs_fall) begin
			next_st.phase      = flash_prog_pkg::PH_CMD;
			next_st.op         = flash_prog_pkg::OP_NONE;
			next_st.bit_cnt    = '0;
			next_st.byte_phase = '0;
			next_st.got_byte   = 1'b0;
			next_st.valid      = '0;
		end
		if (sck_rise) begin
			unique case (st.phase)
				flash_prog_pkg::PH_CMD: begin
					next_st.cmd     = {st.cmd[6:0], fnew.si};
					next_st.bit_cnt = st.bit_cnt + 1'b1;
					if (next_st.bit_cnt == flash_prog_pkg::CMD_BITS) begin
						next_st.phase = flash_prog_pkg::PH_IGNORE;
						// busy ignores all; page commands are refused while in sequential mode
						if (!st.busy && write_enable_latch) begin
							if (next_st.cmd == flash_prog_pkg::CMD_SEQ_A || next_st.cmd == flash_prog_pkg::CMD_SEQ_B) begin
								next_st.op        = flash_prog_pkg::OP_SEQ;
								next_st.seq_first = !st.seq_mode;
								next_st.phase     = st.seq_mode ? flash_prog_pkg::PH_DATA
								                                : flash_prog_pkg::PH_ADDR;
							end else if (!st.seq_mode && next_st.cmd == flash_prog_pkg::CMD_DUAL_PAGE) begin
								next_st.op    = flash_prog_pkg::OP_DUAL;
								next_st.phase = flash_prog_pkg::PH_ADDR;
							end else if (!st.seq_mode && quad_enable
							             && next_st.cmd == flash_prog_pkg::CMD_QUAD_PAGE) begin
								next_st.op    = flash_prog_pkg::OP_QUAD;
								next_st.phase = flash_prog_pkg::PH_ADDR;
							end
						end
					end
				end
				flash_prog_pkg::PH_ADDR: begin
					// address rides serial in alone, most significant bit first
					next_st.start   = {st.start[22:0], fnew.si};
					next_st.bit_cnt = st.bit_cnt + 1'b1;
					next_st.wptr    = {st.start[6:0], fnew.si};
					if (next_st.bit_cnt == flash_prog_pkg::HEADER_BITS)
						next_st.phase = flash_prog_pkg::PH_DATA;
				end
				flash_prog_pkg::PH_DATA: begin
					next_st.shreg      = byte_new;
					next_st.byte_phase = phase_new;
					if (phase_new == '0) begin
						next_st.got_byte = 1'b1;
						if (st.op == flash_prog_pkg::OP_SEQ) begin
							next_st.last_byte = byte_new;
						end else begin
							// slot pointer wraps inside the page, so old bytes are overwritten
							next_st.page[st.wptr]  = byte_new;
							next_st.valid[st.wptr] = 1'b1;
							next_st.wptr           = st.wptr + 1'b1;
						end
					end
				end
				flash_prog_pkg::PH_IGNORE: ;
			endcase
		end
		// release: abort, refuse on protection, or hand the frame to the engine
		if (cs_rise) begin
			next_st.phase = flash_prog_pkg::PH_IGNORE;
			if (frame_prog && !frame_ok) begin
				next_st.wel_clear = 1'b1;
			end else if (frame_prog && first_check && protect_check_hit) begin
				next_st.wel_clear = 1'b1;
			end else if (frame_prog) begin
				next_st.busy    = 1'b1;
				next_st.eng     = flash_prog_pkg::ENG_DRAIN;
				next_st.idx     = '0;
				next_st.job_seq = st.op == flash_prog_pkg::OP_SEQ;
				if (st.op == flash_prog_pkg::OP_SEQ && st.seq_first) begin
					next_st.seq_mode = 1'b1;
					next_st.seq_addr = st.start;
				end
			end
		end
		// engine: drain into the FIFO, stalling on back-pressure, then self-time
		unique case (st.eng)
			flash_prog_pkg::ENG_IDLE: ;
			flash_prog_pkg::ENG_DRAIN: begin
				if (st.job_seq) begin
					if (push_ready) begin
						next_st.at_end = st.seq_addr == flash_prog_pkg::ARRAY_LAST_ADDR;
						if (st.seq_addr != flash_prog_pkg::ARRAY_LAST_ADDR)
							next_st.seq_addr = st.seq_addr + 1'b1;
						next_st.timer = 20'(flash_prog_pkg::BYTE_PROGRAM_CYCLES);
						next_st.eng   = flash_prog_pkg::ENG_WAIT;
					end
				end else if (st.idx == flash_prog_pkg::PAGE_BYTES) begin
					next_st.timer = 20'(PAGE_CYCLES);
					next_st.eng   = flash_prog_pkg::ENG_WAIT;
				end else if (!st.valid[st.idx[7:0]] || push_ready) begin
					next_st.idx = st.idx + 1'b1;
				end
			end
			flash_prog_pkg::ENG_WAIT: begin
				if (st.timer != '0)
					next_st.timer = st.timer - 1'b1;
				if (eng_done) begin
					next_st.busy = 1'b0;
					next_st.eng  = flash_prog_pkg::ENG_IDLE;
					if (st.job_seq && seq_exit) begin
						next_st.seq_mode  = 1'b0;
						next_st.wel_clear = 1'b1;
					end
				end
			end
			default: next_st.eng = flash_prog_pkg::ENG_IDLE;
		endcase
		// losing the enable latch ends sequential mode whatever the cause
		if (st.seq_mode && !write_enable_latch)
			next_st.seq_mode = 1'b0;
		// sticky error flags; a failure in the clearing cycle still sets them
		next_st.pe = (st.pe & ~error_clear) | program_fail;
		next_st.ee = (st.ee & ~error_clear) | program_fail;
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			st        <= '0;
			st.s1     <= '{hold: 1'b1, wp: 1'b1, so: 1'b0, si: 1'b0, sck: 1'b0, cs_n: 1'b1};
			st.s2     <= '{hold: 1'b1, wp: 1'b1, so: 1'b0, si: 1'b0, sck: 1'b0, cs_n: 1'b1};
			st.s3     <= '{hold: 1'b1, wp: 1'b1, so: 1'b0, si: 1'b0, sck: 1'b0, cs_n: 1'b1};
			st.filt   <= '{hold: 1'b1, wp: 1'b1, so: 1'b0, si: 1'b0, sck: 1'b0, cs_n: 1'b1};
			st.phase  <= flash_prog_pkg::PH_IGNORE;
		end else begin
			st <= next_st;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	AST_ABORT_CLEARS_WEL: assert property (cs_rise && frame_prog && !frame_ok |=> wel_clear && !$rose(busy_flag))
		else $error("misaligned or short program frame did not clear the enable latch");
	AST_PROTECT_REFUSED: assert property (cs_rise && frame_prog && frame_ok && first_check && protect_check_hit
		|=> wel_clear ##1 (st.eng == flash_prog_pkg::ENG_IDLE))
		else $error("protected start address was not refused");
	AST_BUSY_ON_RELEASE: assert property (cs_rise && frame_prog && frame_ok && !(first_check && protect_check_hit)
		|=> busy_flag && !wel_clear)
		else $error("valid program frame did not raise busy");
	AST_LAST_ADDR_EXIT: assert property (eng_done && st.job_seq && st.at_end |=> !seq_mode && wel_clear)
		else $error("sequential mode survived the last array location");
	AST_SUSPEND_EXIT: assert property (eng_done && st.job_seq && erase_suspended
		&& st.seq_addr[23:16] == suspended_block |=> !seq_mode)
		else $error("sequential mode entered an erase-suspended block");
	AST_WEL_LOSS_EXIT: assert property (seq_mode && !write_enable_latch |=> !seq_mode)
		else $error("sequential mode kept after enable latch cleared");
	AST_FAIL_FLAGS: assert property (program_fail |=> program_error_flag && erase_error_flag)
		else $error("program failure not reported on both error flags");
	AST_DUAL_BYTE_CLOCKS: assert property (sck_rise && st.phase == flash_prog_pkg::PH_DATA
		&& st.op == flash_prog_pkg::OP_DUAL && st.byte_phase == 3'h6 |=> st.got_byte && st.byte_phase == '0)
		else $error("dual byte not completed on its fourth data clock");
	AST_FRAME_START_CLEAR: assert property (cs_fall |=> st.valid == '0 && st.bit_cnt == '0 && !st.got_byte)
		else $error("frame start left stale buffer or counters");
	// refusals, slot wrap and flag priority that the frame checks only see from outside
	AST_REFUSE_NO_WEL: assert property (sck_rise && st.phase == flash_prog_pkg::PH_CMD
		&& st.bit_cnt == flash_prog_pkg::CMD_BITS - 6'h01 && !write_enable_latch
		|=> st.op == flash_prog_pkg::OP_NONE)
		else $error("program command accepted without the enable latch");
	AST_REFUSE_NO_QUAD: assert property (sck_rise && st.phase == flash_prog_pkg::PH_CMD
		&& st.bit_cnt == flash_prog_pkg::CMD_BITS - 6'h01 && !quad_enable |=> st.op != flash_prog_pkg::OP_QUAD)
		else $error("quad program accepted without quad enable");
	AST_PAGE_SLOT_WRAP: assert property (sck_rise && st.phase == flash_prog_pkg::PH_DATA
		&& st.op != flash_prog_pkg::OP_SEQ && phase_new == '0 |=> st.wptr == 8'($past(st.wptr) + 8'h01))
		else $error("page slot pointer did not step within the page");
	AST_SEQ_KEEPS_LAST: assert property (sck_rise && st.phase == flash_prog_pkg::PH_DATA
		&& st.op == flash_prog_pkg::OP_SEQ && phase_new == '0 |=> st.last_byte == $past(byte_new))
		else $error("sequential frame did not keep its latest byte");
	AST_FLAG_SET_WINS: assert property (program_fail && error_clear
		|=> program_error_flag && erase_error_flag)
		else $error("error clear overrode a failure in the same cycle");
	AST_BUSY_ENDS_IDLE: assert property ($fell(busy_flag)
		|-> st.eng == flash_prog_pkg::ENG_IDLE && !prog_valid)
		else $error("busy dropped while words were still queued");
endmodule

`default_nettype wire

// file: dv/spi_host_model.sv
// SPI host stand-in: drives chip select, serial clock and the four data lanes of the flash front end.
// Assumes one caller at a time; every lane change lands 1 ns after a core_clk rising edge.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input  wire logic core_clk,
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	output logic      so,
	output logic      wp,
	output logic      hold
);
	// deselected, clock parked low
	initial begin
		{cs_n, sck, si, so, wp, hold} = 6'h21;
	end

	// wait n core cycles, landing just after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// one serial clock of 160 ns; lanes settle a half period before the rising edge
	task automatic pulse(input logic [3:0] lanes);
		{hold, wp, so, si} = lanes;
		tick(10);
		sck = 1'b1;
		tick(10);
		sck = 1'b0;
	endtask

	// one byte, most significant group first, over 1, 2 or 4 lanes
	task automatic put_byte(input logic [7:0] b, input int lanes);
		for (int k = 8 / lanes - 1; k >= 0; k--) pulse(4'((b >> (k * lanes)) & ((1 << lanes) - 1)));
	endtask

	// whole frame; extra single-lane clocks break the byte boundary on purpose
	task automatic frame(input logic [7:0] cmd, input logic [23:0] addr, input bit with_addr, input int lanes,
		input int nbytes, input logic [7:0] base, input int extra);
		cs_n = 1'b0;
		tick(10);
		put_byte(cmd, 1);
		if (with_addr) for (int i = 2; i >= 0; i--) put_byte(addr[i * 8 +: 8], 1);
		for (int i = 0; i < nbytes; i++) put_byte(base + 8'(i), lanes);
		repeat (extra) pulse(4'h1);
		tick(10);
		cs_n = 1'b1;
		{hold, wp, so, si} = ~{hold, wp, so, si}; // released lanes must not keep their last value
		tick(10);
	endtask
endmodule
`default_nettype wire

// file: dv/flash_prog_frontend_test.sv
// Self-checking bench for the program-command front end, frames sent through the SPI host stand-in.
// Assumes 64 kB block 05 is protected, block 03 is the suspended one, and a short page time.
`timescale 1ns/1ps
`default_nettype none
module flash_prog_frontend_test;
	logic        core_clk, resetn, cs_n, sck, si, so, wp, hold, so_out, so_oe, wel_arm;
	logic        write_enable_latch, quad_enable, wel_clear, erase_suspended, error_clear, program_fail;
	logic        busy_flag, seq_mode, program_error_flag, erase_error_flag, prog_valid, prog_ready;
	logic [23:0] protect_check_addr, seq_next_addr;
	logic [7:0]  base;
	logic [2:0]  cyc;
	int          n_fail, total_checks, wel_cnt;
	bit          busy_seen, oe_bad, clr_now;
	wire logic   so_line;
	flash_prog_pkg::prog_word_t prog_word;
	flash_prog_pkg::prog_word_t got[$];

	assign so_line = so_oe ? so_out : so;

	spi_host_model host (.core_clk(core_clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .wp(wp), .hold(hold));

	flash_prog_frontend #(.PAGE_CYCLES(50)) DUT (.core_clk(core_clk), .resetn(resetn), .chip_select_n_pin(cs_n),
		.serial_clk_pin(sck), .serial_in_pin(si), .serial_out_pin_in(so_line), .serial_out_pin_out(so_out),
		.serial_out_pin_oe(so_oe), .write_protect_pin(wp), .pause_io3_pin(hold),
		.write_enable_latch(write_enable_latch), .quad_enable(quad_enable), .wel_clear(wel_clear),
		.protect_check_addr(protect_check_addr), .protect_check_hit(protect_check_addr[23:16] == 8'h05),
		.seq_next_addr(seq_next_addr), .seq_next_protected(seq_next_addr[23:16] == 8'h05),
		.erase_suspended(erase_suspended), .suspended_block(8'h03), .busy_flag(busy_flag), .seq_mode(seq_mode),
		.program_error_flag(program_error_flag), .erase_error_flag(erase_error_flag), .error_clear(error_clear),
		.program_fail(program_fail), .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_word(prog_word));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// array writer and enable latch stand-ins; the writer stalls most cycles so the FIFO fills
	always @(posedge core_clk) begin
		if (prog_valid === 1'b1 && prog_ready === 1'b1) got.push_back(prog_word);
		clr_now = (wel_clear === 1'b1);
		if (clr_now) wel_cnt++;
		if (busy_flag === 1'b1) busy_seen = 1'b1;
		if ((so_oe !== 1'b0 || so_out !== 1'b0) && resetn === 1'b1) oe_bad = 1'b1;
		#1 prog_ready = (cyc == 3'h0) || (cyc == 3'h5);
		cyc = cyc + 3'h1;
		if (clr_now) write_enable_latch = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic finish_test;
		if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// one frame, then wait out busy and compare clears, busy and every programmed word
	task automatic run(input logic [7:0] cmd, input logic [23:0] addr, input bit with_addr, input int lanes,
		input int nbytes, input int extra, input int exp_clr, input bit exp_busy);
		logic [7:0]                 pg [256];
		bit                         used [256];
		flash_prog_pkg::prog_word_t exp[$];
		int                         n;
		base = base + 8'h11;
		write_enable_latch = wel_arm;
		got.delete();
		wel_cnt = 0;
		busy_seen = 1'b0;
		host.frame(cmd, addr, with_addr, lanes, nbytes, base, extra);
		n = 0;
		while (n < 40000 && (n < 20 || busy_flag !== 1'b0)) begin
			tick(1);
			n++;
		end
		if (n == 40000) begin
			n_fail++;
			finish_test();
		end
		tick(2);
		if (exp_busy && (cmd == flash_prog_pkg::CMD_SEQ_A || cmd == flash_prog_pkg::CMD_SEQ_B))
			exp.push_back({addr, base + 8'(nbytes - 1)});
		else if (exp_busy) begin
			for (int i = 0; i < nbytes; i++) begin
				pg[addr[7:0] + 8'(i)] = base + 8'(i);
				used[addr[7:0] + 8'(i)] = 1'b1;
			end
			for (int s = 0; s < 256; s++) if (used[s]) exp.push_back({addr[23:8], 8'(s), pg[s]});
		end
		chk(wel_cnt, exp_clr);
		chk(busy_seen, exp_busy);
		chk(got.size(), exp.size());
		foreach (exp[i]) if (i < got.size()) chk(got[i], exp[i]);
	endtask

	initial begin
		{resetn, write_enable_latch, quad_enable, erase_suspended, error_clear, program_fail, prog_ready} = 7'h00;
		base = 8'h00;
		cyc = 3'h0;
		wel_arm = 1'b1;
		tick(10);
		resetn = 1'b1;
		tick(4);
		quad_enable = 1'b1;
		run(flash_prog_pkg::CMD_DUAL_PAGE, 24'h0000FE, 1, 2, 3, 0, 0, 1);
		run(flash_prog_pkg::CMD_QUAD_PAGE, 24'h000100, 1, 4, 2, 0, 0, 1);
		run(flash_prog_pkg::CMD_DUAL_PAGE, 24'h000000, 1, 2, 257, 0, 0, 1);
		run(flash_prog_pkg::CMD_DUAL_PAGE, 24'h000040, 1, 2, 1, 3, 1, 0);
		run(flash_prog_pkg::CMD_DUAL_PAGE, 24'h000000, 0, 1, 2, 0, 1, 0);
		run(flash_prog_pkg::CMD_QUAD_PAGE, 24'h000040, 1, 4, 1, 1, 1, 0);
		run(flash_prog_pkg::CMD_DUAL_PAGE, 24'h050000, 1, 2, 2, 0, 1, 0);
		quad_enable = 1'b0;
		run(flash_prog_pkg::CMD_QUAD_PAGE, 24'h000000, 1, 4, 1, 0, 0, 0);
		quad_enable = 1'b1;
		wel_arm = 1'b0;
		run(flash_prog_pkg::CMD_DUAL_PAGE, 24'h000200, 1, 2, 1, 0, 0, 0);
		wel_arm = 1'b1;
		run(flash_prog_pkg::CMD_SEQ_A, 24'h000010, 1, 1, 1, 0, 0, 1);
		chk(seq_mode, 1'b1);
		run(flash_prog_pkg::CMD_SEQ_B, 24'h000011, 0, 1, 1, 0, 0, 1);
		write_enable_latch = 1'b0;
		tick(3);
		chk(seq_mode, 1'b0);
		run(flash_prog_pkg::CMD_SEQ_A, 24'h050010, 1, 1, 1, 0, 1, 0);
		run(flash_prog_pkg::CMD_SEQ_A, 24'h000020, 1, 1, 1, 5, 1, 0);
		run(flash_prog_pkg::CMD_SEQ_A, 24'h04FFFF, 1, 1, 1, 0, 1, 1);
		chk(seq_mode, 1'b0);
		erase_suspended = 1'b1;
		run(flash_prog_pkg::CMD_SEQ_B, 24'h02FFFF, 1, 1, 1, 0, 1, 1);
		chk(seq_mode, 1'b0);
		run(flash_prog_pkg::CMD_SEQ_A, 24'h0FFFFF, 1, 1, 3, 0, 1, 1);
		chk(seq_mode, 1'b0);
		program_fail = 1'b1;
		tick(1);
		program_fail = 1'b0;
		tick(1);
		chk({erase_error_flag, program_error_flag}, 2'h3);
		program_fail = 1'b1;
		error_clear = 1'b1;
		tick(1);
		{program_fail, error_clear} = 2'h0;
		tick(1);
		chk({erase_error_flag, program_error_flag}, 2'h3);
		error_clear = 1'b1;
		tick(1);
		error_clear = 1'b0;
		tick(1);
		chk({erase_error_flag, program_error_flag}, 2'h0);
		chk(oe_bad, 1'b0);
		finish_test();
	end
endmodule
`default_nettype wire
